// ### qdw_map.vh
`ifndef QDW_MAP_VH
`define QDW_MAP_VH
// ----------------------------------------
// Address byte layout
// ----------------------------------------
`define QDW_ADDR_PREFIX 5'h13
`define QDW_HS_CODE 5'h01
`define QDW_RW_BIT 0
// ----------------------------------------
// Control and power-down byte fields
// ----------------------------------------
`define QDW_CTRL_PKG_HI 7
`define QDW_CTRL_PKG_LO 6
`define QDW_CTRL_UPD_HI 5
`define QDW_CTRL_UPD_LO 4
`define QDW_CTRL_PICK_HI 2
`define QDW_CTRL_PICK_LO 1
`define QDW_CTRL_KIND 0
`define QDW_PD_HI_BIT 7
`define QDW_PD_LO_BIT 6
// ----------------------------------------
// Update modes
// ----------------------------------------
`define QDW_UPD_TEMP 2'h0
`define QDW_UPD_ONE 2'h1
`define QDW_UPD_ALL 2'h2
`define QDW_UPD_BCAST 2'h3
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define QDW_REG_RST 18'h00000
`define QDW_CTRL_RST 8'h00
`define QDW_BYTE_RST 8'h00
`define QDW_SYNC_RST 6'h03
`define QDW_BITS_PER_BYTE 4'h8
`endif

// ### qdw_master.sv
module qdw_master (
  input wire i_clk,
  input wire i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Bus master model
  // ----
  task w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task bit_(input logic b, output logic r);
    w(3);
    o_sda <= b;
    w(3);
    o_scl <= 1'b1;
    w(1);
    r = i_sda;
    w(1);
    o_scl <= 1'b0;
  endtask
  // Start or repeated start
  task start;
    w(3);
    o_sda <= 1'b1;
    w(3);
    o_scl <= 1'b1;
    w(3);
    o_sda <= 1'b0;
    w(3);
    o_scl <= 1'b0;
  endtask
  task stop;
    w(3);
    o_sda <= 1'b0;
    w(3);
    o_scl <= 1'b1;
    w(3);
    o_sda <= 1'b1;
    w(6);
  endtask
  task xfer(input [7:0] b, output int k);
    logic r;
    for (int i = 7; i >= 0; i--) bit_(b[i], r);
    bit_(1'b1, r);
    k = (r === 1'b0) ? 1 : (r === 1'b1) ? 0 : 16;
  endtask
endmodule // qdw_master

// ### qdw_rx.v
// Behaviour
// - Address prefix 10011, straps, R/W match
// - Control byte sets mode and channel
// - Control fields: package, update, pick, kind
// - Lowest control bit selects power-down data
// - High/low pairs repeat until stop/restart
// - Code arrives high byte first, MSB first
// - Exactly two power-down bytes accepted
// - Acknowledge address, control and data bytes
// - High-speed master code never acknowledged
// - Update at falling edge ending acknowledge
// - Eighteen-bit temporary register per channel
module qdw_rx (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_scl,
  input wire i_sda,
  input wire i_strap_addr_bit1,
  input wire i_strap_addr_bit0,
  input wire i_pkg_strap_hi,
  input wire i_pkg_strap_lo,
  output wire o_sda_out,
  output wire o_sda_oe_n,
  output reg o_hs_mode,
  output reg [7:0] o_ctrl_byte,
  output wire [71:0] o_temp_regs,
  output wire [71:0] o_dac_regs
);
`include "qdw_map.vh"

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_ADDR = 8'h02;
  localparam [7:0] S_CTRL = 8'h04;
  localparam [7:0] S_HIGH = 8'h08;
  localparam [7:0] S_LOW = 8'h10;
  localparam [7:0] S_PD1 = 8'h20;
  localparam [7:0] S_PD2 = 8'h40;
  localparam [7:0] S_SKIP = 8'h80;

  // ----------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------
  wire [5:0] sync_bus;
  wire scl;
  wire sda;
  wire [1:0] addr_strap;
  wire [1:0] pkg_strap;
  reg scl_d;
  reg sda_d;

  qdw_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async({i_pkg_strap_hi, i_pkg_strap_lo, i_strap_addr_bit1, i_strap_addr_bit0,
              i_sda, i_scl}),
    .o_sync(sync_bus)
  );

  assign scl = sync_bus[0];
  assign sda = sync_bus[1];
  assign addr_strap = sync_bus[3:2];
  assign pkg_strap = sync_bus[5:4];

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------
  // Byte framing
  // ----------------------------------------
  reg [7:0] state;
  reg [3:0] bit_cnt;
  reg ack_phase;
  reg sda_drive;
  reg [7:0] shreg;
  reg [7:0] hi_byte;
  reg [1:0] pd_bits;
  reg ack_ok;
  reg [7:0] next_state;

  wire addr_match = (shreg[7:3] == `QDW_ADDR_PREFIX) && (shreg[2:1] == addr_strap) &&
                    !shreg[`QDW_RW_BIT];
  wire hs_code = (shreg[7:3] == `QDW_HS_CODE);
  wire ack_end = scl_fall & ack_phase & ~start_cond & ~stop_cond;

  wire [1:0] upd_mode = {o_ctrl_byte[`QDW_CTRL_UPD_HI], o_ctrl_byte[`QDW_CTRL_UPD_LO]};
  wire [1:0] pick = {o_ctrl_byte[`QDW_CTRL_PICK_HI], o_ctrl_byte[`QDW_CTRL_PICK_LO]};
  wire pkg_ok = ({o_ctrl_byte[`QDW_CTRL_PKG_HI], o_ctrl_byte[`QDW_CTRL_PKG_LO]} == pkg_strap)
                || (upd_mode == `QDW_UPD_BCAST);

  // Ack decision and successor state per received byte
  always @* begin
    ack_ok = 1'b0;
    next_state = S_SKIP;
    case (state)
      S_ADDR: begin
        ack_ok = addr_match;
        next_state = addr_match ? S_CTRL : S_SKIP;
      end
      S_CTRL: begin
        ack_ok = 1'b1;
        if (shreg[`QDW_CTRL_KIND]) begin
          next_state = S_PD1;
        end else if ({shreg[`QDW_CTRL_UPD_HI], shreg[`QDW_CTRL_UPD_LO]} == `QDW_UPD_BCAST &&
                     !shreg[`QDW_CTRL_PICK_HI]) begin
          next_state = S_SKIP;
        end else begin
          next_state = S_HIGH;
        end
      end
      S_HIGH: begin
        ack_ok = 1'b1;
        next_state = S_LOW;
      end
      S_LOW: begin
        ack_ok = 1'b1;
        next_state = S_HIGH;
      end
      S_PD1: begin
        ack_ok = 1'b1;
        next_state = S_PD2;
      end
      S_PD2: begin
        ack_ok = 1'b1;
        next_state = S_SKIP;
      end
      default: begin
        ack_ok = 1'b0;
        next_state = S_SKIP;
      end
    endcase
  end

  wire active = (state != S_IDLE) && (state != S_SKIP);

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_drive <= 1'b0;
      shreg <= `QDW_BYTE_RST;
      hi_byte <= `QDW_BYTE_RST;
      pd_bits <= 2'h0;
      o_hs_mode <= 1'b0;
      o_ctrl_byte <= `QDW_CTRL_RST;
    end else if (start_cond) begin
      state <= S_ADDR;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_drive <= 1'b0;
    end else if (stop_cond) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_drive <= 1'b0;
      o_hs_mode <= 1'b0;
    end else if (active) begin
      if (scl_rise && !ack_phase && bit_cnt != `QDW_BITS_PER_BYTE) begin
        shreg <= {shreg[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (scl_fall && !ack_phase && bit_cnt == `QDW_BITS_PER_BYTE) begin
        ack_phase <= 1'b1;
        sda_drive <= ack_ok;
      end
      if (ack_end) begin
        ack_phase <= 1'b0;
        sda_drive <= 1'b0;
        bit_cnt <= 4'h0;
        state <= next_state;
        if (state == S_ADDR && hs_code) begin
          o_hs_mode <= 1'b1;
        end
        if (state == S_CTRL) begin
          o_ctrl_byte <= shreg;
        end
        if (state == S_HIGH) begin
          hi_byte <= shreg;
        end
        if (state == S_PD1) begin
          pd_bits <= {shreg[`QDW_PD_HI_BIT], shreg[`QDW_PD_LO_BIT]};
        end
      end
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = ~sda_drive;

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  function ch_hit;
    input [1:0] mode;
    input [1:0] sel;
    input [1:0] idx;
    begin
      ch_hit = (mode == `QDW_UPD_BCAST) || (sel == idx);
    end
  endfunction

  wire data_done = ack_end && (state == S_LOW) && pkg_ok;
  wire pd_done = ack_end && (state == S_PD2) && pkg_ok;
  wire bcast_upd = ack_end && (state == S_CTRL) && !shreg[`QDW_CTRL_KIND] &&
                   ({shreg[`QDW_CTRL_UPD_HI], shreg[`QDW_CTRL_UPD_LO]} == `QDW_UPD_BCAST) &&
                   !shreg[`QDW_CTRL_PICK_HI];
  wire [15:0] code = {hi_byte, shreg};
  wire load_all = (data_done || pd_done) &&
                  (upd_mode == `QDW_UPD_ALL || upd_mode == `QDW_UPD_BCAST);

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      reg [17:0] temp_reg;
      reg [17:0] dac_reg;
      localparam [1:0] CH_IDX = ch;
      wire wr = (data_done || pd_done) && ch_hit(upd_mode, pick, CH_IDX);
      wire [17:0] next_temp = !wr ? temp_reg :
                              data_done ? {2'h0, code} : {pd_bits, temp_reg[15:0]};
      wire load = load_all || bcast_upd || (wr && upd_mode == `QDW_UPD_ONE);

      always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          temp_reg <= `QDW_REG_RST;
          dac_reg <= `QDW_REG_RST;
        end else begin
          temp_reg <= next_temp;
          if (load) begin
            dac_reg <= next_temp;
          end
        end
      end

      assign o_temp_regs[ch*18 +: 18] = temp_reg;
      assign o_dac_regs[ch*18 +: 18] = dac_reg;
    end
  endgenerate
endmodule // qdw_rx

// ### qdw_rx_bench.sv
`include "qdw_map.vh"
module qdw_rx_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n = 0;
  logic [1:0] st = 2'h2, pk = 2'h1;
  logic [17:0] et[4], ed[4];
  logic [15:0] rnd = 16'h0037;
  logic [7:0] adr, ctl;
  int n_mismatch = 0, checks_done = 0, na;
  wire sda, scl, sda_m, oe_n, so, hs;
  wire [7:0] cb;
  wire [71:0] tr, dr;
  assign sda = sda_m & (oe_n | so);
  qdw_master M(.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
  qdw_rx DUT(.i_sys_clk(clk), .i_resetn(rst_n), .i_scl(scl), .i_sda(sda),
    .i_strap_addr_bit1(st[1]), .i_strap_addr_bit0(st[0]), .i_pkg_strap_hi(pk[1]),
    .i_pkg_strap_lo(pk[0]), .o_sda_out(so), .o_sda_oe_n(oe_n), .o_hs_mode(hs),
    .o_ctrl_byte(cb), .o_temp_regs(tr), .o_dac_regs(dr));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  function automatic [15:0] lfsr(input [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task chk(input string nm, input [71:0] e, input [71:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task regs_ok(input int a);
    chk("acks", a, na);
    chk("temp", {et[3], et[2], et[1], et[0]}, tr);
    chk("dac", {ed[3], ed[2], ed[1], ed[0]}, dr);
    $display("test done, %0d checks", checks_done);
  endtask
  task upd(input [1:0] m, input [1:0] c, input [17:0] v);
    et[c] = v;
    if (m == 3) et = '{default: v};
    if (m == 1) ed[c] = v;
    if (m >= 2) ed = et;
  endtask
  task tx(input [7:0] a, input [7:0] c, input [31:0] d, input int nb);
    int k;
    M.start;
    M.xfer(a, k);
    na = k;
    if (k) begin
      M.xfer(c, k);
      na += k;
      for (int i = 0; i < nb; i++) begin
        M.xfer(d[31 - 8 * i -: 8], k);
        na += k;
      end
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_mismatch++;
    close_out;
  end
  initial begin
    et = '{default: 0};
    ed = '{default: 0};
    adr = {`QDW_ADDR_PREFIX, st, 1'b0};
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (6) @(posedge clk);
    na = 0;
    regs_ok(0);
    for (int j = 0; j < 12; j++) begin
      rnd = lfsr(rnd);
      ctl = {pk, j[3:2], 1'b0, j[1:0], 1'b0};
      tx(adr, ctl, {rnd, 16'h0}, 2);
      M.stop;
      upd(j[3:2], j[1:0], {2'h0, rnd});
      regs_ok(4);
      chk("ctrl", ctl, cb);
    end
    rnd = lfsr(rnd);
    tx(adr, {pk, 2'h1, 4'h6}, {rnd, ~rnd}, 4);
    chk("acks", 6, na);
    upd(1, 3, {2'h0, ~rnd});
    tx(adr, {pk, 2'h1, 4'h6}, 32'hab00_0000, 1);
    M.stop;
    regs_ok(3);
    tx(adr, {pk, 2'h1, 4'h3}, 32'h8000_ff00, 3);
    M.stop;
    upd(1, 1, {2'h2, et[1][15:0]});
    regs_ok(4);
    tx({`QDW_ADDR_PREFIX, ~st, 1'b0}, 8'h0, 32'h0, 0);
    M.stop;
    regs_ok(0);
    tx({adr[7:1], 1'b1}, 8'h0, 32'h0, 0);
    M.stop;
    regs_ok(0);
    tx(adr, {~pk, 2'h1, 4'h0}, 32'h1234_0000, 2);
    M.stop;
    regs_ok(4);
    rnd = lfsr(rnd);
    tx(adr, {pk, 2'h0, 4'h4}, {rnd, 16'h0}, 2);
    M.stop;
    upd(0, 2, {2'h0, rnd});
    regs_ok(4);
    tx(adr, {~pk, 2'h3, 4'h0}, 32'h0, 0);
    M.stop;
    ed = et;
    regs_ok(2);
    rnd = lfsr(rnd);
    tx(adr, {~pk, 2'h3, 4'h4}, {rnd, 16'h0}, 2);
    M.stop;
    upd(3, 0, {2'h0, rnd});
    regs_ok(4);
    tx(8'h08, 8'h0, 32'h0, 0);
    chk("hs acks", 0, na);
    rnd = lfsr(rnd);
    tx(adr, {pk, 2'h2, 4'h0}, {rnd, 16'h0}, 2);
    upd(2, 0, {2'h0, rnd});
    chk("hs", 1, hs);
    M.stop;
    regs_ok(4);
    chk("hs", 0, hs);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (6) @(posedge clk);
    et = '{default: 0};
    ed = '{default: 0};
    na = 0;
    regs_ok(0);
    chk("ctrl", 0, cb);
    close_out;
  end
endmodule // qdw_rx_bench
bind qdw_rx qdw_rx_properties u_props(.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
  .o_hs_mode(o_hs_mode), .o_ctrl_byte(o_ctrl_byte), .o_temp_regs(o_temp_regs),
  .o_dac_regs(o_dac_regs));

// ### qdw_rx_properties.sv
module qdw_rx_properties (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe_n,
  input wire o_hs_mode,
  input wire [7:0] o_ctrl_byte,
  input wire [71:0] o_temp_regs,
  input wire [71:0] o_dac_regs
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Link checks
  // ----
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  AST_ACK_LEVEL: assert property (!o_sda_oe_n |-> !o_sda_out)
    else $error("ack level");
  AST_ACK_HOLD: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*6])
    else $error("ack short");
  AST_ACK_END: assert property ($rose(o_sda_oe_n) |-> !i_scl)
    else $error("ack end");
  AST_HS_NOACK: assert property ($rose(o_hs_mode) |-> $past(o_sda_oe_n, 4))
    else $error("code acked");
  AST_HS_STOP: assert property ($fell(o_hs_mode) |-> i_scl && i_sda)
    else $error("hs drop");
  AST_CTRL_LOW: assert property ($changed(o_ctrl_byte) |-> !i_scl)
    else $error("ctrl time");
  AST_DAC_LOW: assert property ($changed(o_dac_regs) |-> !i_scl)
    else $error("dac time");
  AST_TEMP_LOW: assert property ($changed(o_temp_regs) |-> !i_scl)
    else $error("temp time");
  cover property ($rose(o_hs_mode));
  cover property ($changed(o_dac_regs));
  cover property ($fell(o_sda_oe_n));
endmodule // qdw_rx_properties

// ### qdw_sync.v
// ----------------------------------------
// Two-stage synchroniser for pins
// ----------------------------------------
module qdw_sync (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [5:0] i_async,
  output reg [5:0] o_sync
);
`include "qdw_map.vh"

  reg [5:0] meta;

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= `QDW_SYNC_RST;
      o_sync <= `QDW_SYNC_RST;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // qdw_sync
